// [pkg/dcf_pkg.sv]
// constants and types shared by the dual-clock fifo flag block
package dcf_pkg;

   localparam int          DATA_W        = 36;
   localparam int          ADDR_W        = 11;
   localparam int          PTR_W         = 12;
   localparam int          OFFSET_W      = 11;
   localparam int          MEM_DEPTH     = 2048;
   localparam int          STAGE_DEPTH   = 8;

   localparam logic [PTR_W-1:0] PTR_RESET  = 12'h000;
   localparam logic [PTR_W-1:0] PTR_ONE    = 12'h001;
   localparam logic [PTR_W-1:0] FILL_FULL  = 12'h800;

   localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;

   // replay is allowed once this many reads have passed the mark
   localparam logic [1:0]  REPLAY_MIN_READS = 2'h2;
   localparam logic [1:0]  READS_RESET      = 2'h0;
   localparam logic [1:0]  READS_ONE        = 2'h1;

   // clock rate and the edge-to-edge skew that qualifies a first sync cycle
   localparam int          CLK_PERIOD_PS = 10000;
   localparam int          T_SK_PS       = 10000;
   localparam int          SK_CYCLES     = (T_SK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic {
      DCF_NORMAL = 1'b0,
      DCF_RETX   = 1'b1
   } dcf_mode_t;

endpackage

// [core/dcf_stage_fifo.sv]
// small valid/ready staging fifo with parameterised width and depth
`timescale 1ns/1ps
module dcf_stage_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,       // system clock
   input  wire logic             rst_i,       // synchronous reset, active high
   input  wire logic             in_valid_i,  // source offers a word
   output logic                  in_ready_o,  // room for a word
   input  wire logic [WIDTH-1:0] in_data_i,   // word offered
   output logic                  out_valid_o, // a word is waiting
   input  wire logic             out_ready_i, // sink takes the word
   output logic      [WIDTH-1:0] out_data_o   // oldest word
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    head_r;
   logic [PW-1:0]    tail_r;
   logic [CW-1:0]    count_r;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_r != CW'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = store[head_r];

   always_ff @(posedge clk_i) begin
      if (push) begin
         store[tail_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_r  <= '0;
         tail_r  <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            tail_r <= (tail_r == PW'(DEPTH - 1)) ? '0 : tail_r + PW'(1);
         end
         if (pop) begin
            head_r <= (head_r == PW'(DEPTH - 1)) ? '0 : head_r + PW'(1);
         end
         if (push && !pop) begin
            count_r <= count_r + CW'(1);
         end else if (pop && !push) begin
            count_r <= count_r - CW'(1);
         end
      end
   end

endmodule

// [core/dcf_fifo_flags.sv]
// 2048-word fifo with port-synchronised flags and synchronous retransmit
`timescale 1ns/1ps
module dcf_fifo_flags (
   input  wire logic                         CLOCK_I,                  // system clock
   input  wire logic                         RST_I,                    // sync reset, high
   input  wire logic                         WRITE_PORT_TICK_I,        // write port edge
   input  wire logic                         WRITE_PORT_SELECT_N_I,    // write select, low
   input  wire logic                         WRITE_PORT_MAILBOX_SEL_I, // mailbox instead
   input  wire logic                         WRITE_PORT_DIRECTION_I,   // high for write
   input  wire logic                         WRITE_PORT_STROBE_I,      // write enable
   input  wire logic [dcf_pkg::DATA_W-1:0]   WRITE_DATA_I,             // word to store
   input  wire logic                         READ_PORT_TICK_I,         // read port edge
   input  wire logic                         READ_PORT_SELECT_N_I,     // read select, low
   input  wire logic                         READ_PORT_MAILBOX_SEL_I,  // mailbox instead
   input  wire logic                         READ_PORT_DIRECTION_I,    // high for read
   input  wire logic                         READ_PORT_STROBE_I,       // read enable
   input  wire logic                         RETRANSMIT_HOLD_I,        // retransmit mode
   input  wire logic                         REPLAY_FROM_MARK_I,       // replay request
   input  wire logic [dcf_pkg::OFFSET_W-1:0] EMPTY_OFFSET_I,           // offset x
   input  wire logic [dcf_pkg::OFFSET_W-1:0] FULL_OFFSET_I,            // offset y
   output logic      [dcf_pkg::DATA_W-1:0]   READ_DATA_O,              // output register
   output logic                              OUTPUT_READY_O,           // fresh word held
   output logic                              ALMOST_EMPTY_N_O,         // low near empty
   output logic                              INPUT_READY_O,            // room to write
   output logic                              ALMOST_FULL_N_O,          // low near full
   output logic                              RETRANSMIT_ACTIVE_O       // mode state
);

   localparam int PW = dcf_pkg::PTR_W;
   localparam int AW = dcf_pkg::ADDR_W;
   localparam int DW = dcf_pkg::DATA_W;

   // word count between a producer and a consumer pointer
   function automatic logic [PW-1:0] fill(input logic [PW-1:0] wr_p,
                                          input logic [PW-1:0] rd_p);
      fill = wr_p - rd_p;
   endfunction

   // shared port decode for both fifo ports
   function automatic logic port_req(input logic tick,
                                     input logic sel_n,
                                     input logic mbx,
                                     input logic dir,
                                     input logic strobe);
      port_req = tick && !sel_n && !mbx && dir && strobe;
   endfunction

   logic [DW-1:0]     mem [dcf_pkg::MEM_DEPTH];

   // write side state
   logic [PW-1:0]     wr_count_ptr_r;
   logic [PW-1:0]     wr_count_ptr_nxt;
   logic [PW-1:0]     rd_seen_r;
   logic              in_ready_r;
   logic              almost_full_n_r;
   logic              wr_req;
   logic              wr_accept;

   // staging fifo and physical memory write
   logic              stage_in_ready;
   logic              stage_out_valid;
   logic              stage_out_ready;
   logic [DW-1:0]     stage_out_data;
   logic [PW-1:0]     mem_wptr_r;
   logic [PW-1:0]     mem_wptr_pub_r;

   // read side state
   dcf_pkg::dcf_mode_t mode_r;
   dcf_pkg::dcf_mode_t mode_nxt;
   logic [PW-1:0]     wr_seen1_r;
   logic [PW-1:0]     wr_seen2_r;
   logic [PW-1:0]     rd_cur_r;
   logic [PW-1:0]     rd_cur_nxt;
   logic [PW-1:0]     rd_shadow_r;
   logic [PW-1:0]     rd_flag_ptr_r;
   logic [PW-1:0]     rd_flag_pub_r;
   logic [1:0]        reads_past_r;
   logic [DW-1:0]     out_word_r;
   logic              out_ready_r;
   logic              almost_empty_n_r;
   logic              rd_req;
   logic              replay;
   logic              load_word;
   logic              have_word;

   assign wr_req = port_req(WRITE_PORT_TICK_I, WRITE_PORT_SELECT_N_I,
                            WRITE_PORT_MAILBOX_SEL_I, WRITE_PORT_DIRECTION_I,
                            WRITE_PORT_STROBE_I);
   assign wr_accept = wr_req && in_ready_r && stage_in_ready;
   assign wr_count_ptr_nxt = wr_accept ? wr_count_ptr_r + dcf_pkg::PTR_ONE
                                       : wr_count_ptr_r;

   assign rd_req = port_req(READ_PORT_TICK_I, READ_PORT_SELECT_N_I,
                            READ_PORT_MAILBOX_SEL_I, READ_PORT_DIRECTION_I,
                            READ_PORT_STROBE_I) && out_ready_r;

   // replay wins over a read on the same edge; exit edge must not replay
   assign replay    = READ_PORT_TICK_I && (mode_r == dcf_pkg::DCF_RETX) &&
                      RETRANSMIT_HOLD_I && REPLAY_FROM_MARK_I &&
                      (reads_past_r >= dcf_pkg::REPLAY_MIN_READS);
   assign have_word = (wr_seen2_r != rd_cur_r);
   assign load_word = READ_PORT_TICK_I && !replay &&
                      (!out_ready_r || rd_req) && have_word;

   always_comb begin
      rd_cur_nxt = rd_cur_r;
      if (replay) begin
         rd_cur_nxt = rd_shadow_r;
      end else if (load_word) begin
         rd_cur_nxt = rd_cur_r + dcf_pkg::PTR_ONE;
      end
   end

   always_comb begin
      mode_nxt = mode_r;
      if (READ_PORT_TICK_I) begin
         if (!RETRANSMIT_HOLD_I) begin
            mode_nxt = dcf_pkg::DCF_NORMAL;
         end else if (mode_r == dcf_pkg::DCF_NORMAL && out_ready_r) begin
            mode_nxt = dcf_pkg::DCF_RETX;
         end
      end
   end

   // writes land in the staging fifo first; it drains while memory has room
   dcf_stage_fifo #(
      .WIDTH (DW),
      .DEPTH (dcf_pkg::STAGE_DEPTH)
   ) u_stage (
      .clk_i       (CLOCK_I),
      .rst_i       (RST_I),
      .in_valid_i  (wr_accept),
      .in_ready_o  (stage_in_ready),
      .in_data_i   (WRITE_DATA_I),
      .out_valid_o (stage_out_valid),
      .out_ready_i (stage_out_ready),
      .out_data_o  (stage_out_data)
   );

   // back-pressure from the memory itself, judged on the freed-location pointer
   assign stage_out_ready = (fill(mem_wptr_r, rd_flag_ptr_r) != dcf_pkg::FILL_FULL);

   always_ff @(posedge CLOCK_I) begin
      if (stage_out_valid && stage_out_ready) begin
         mem[mem_wptr_r[AW-1:0]] <= stage_out_data;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         mem_wptr_r <= dcf_pkg::PTR_RESET;
      end else if (stage_out_valid && stage_out_ready) begin
         mem_wptr_r <= mem_wptr_r + dcf_pkg::PTR_ONE;
      end
   end

   // one clock of publish delay is the skew that qualifies a first sync edge
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         mem_wptr_pub_r <= dcf_pkg::PTR_RESET;
         rd_flag_pub_r  <= dcf_pkg::PTR_RESET;
      end else begin
         mem_wptr_pub_r <= mem_wptr_r;
         rd_flag_pub_r  <= rd_flag_ptr_r;
      end
   end

   // ---- write port side: everything moves on the write tick
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         wr_count_ptr_r <= dcf_pkg::PTR_RESET;
      end else begin
         wr_count_ptr_r <= wr_count_ptr_nxt;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         rd_seen_r <= dcf_pkg::PTR_RESET;
      end else if (WRITE_PORT_TICK_I) begin
         rd_seen_r <= rd_flag_pub_r;
      end
   end

   // a write drops the flags at once; a read raises them on the second tick
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         in_ready_r <= 1'b0;
      end else if (WRITE_PORT_TICK_I) begin
         in_ready_r <= (fill(wr_count_ptr_nxt, rd_seen_r)
                        != dcf_pkg::FILL_FULL);
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         almost_full_n_r <= 1'b1;
      end else if (WRITE_PORT_TICK_I) begin
         almost_full_n_r <= (fill(wr_count_ptr_nxt, rd_seen_r) <
                             (dcf_pkg::FILL_FULL - PW'(FULL_OFFSET_I)));
      end
   end

   // ---- read port side: everything moves on the read tick
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         wr_seen1_r <= dcf_pkg::PTR_RESET;
         wr_seen2_r <= dcf_pkg::PTR_RESET;
      end else if (READ_PORT_TICK_I) begin
         wr_seen1_r <= mem_wptr_pub_r;
         wr_seen2_r <= wr_seen1_r;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         rd_cur_r <= dcf_pkg::PTR_RESET;
      end else begin
         rd_cur_r <= rd_cur_nxt;
      end
   end

   // output register keeps the old word whenever nothing fresh arrives
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         out_word_r <= dcf_pkg::DATA_RESET;
      end else if (replay) begin
         out_word_r <= mem[rd_shadow_r[AW-1:0] - AW'(1)];
      end else if (load_word) begin
         out_word_r <= mem[rd_cur_r[AW-1:0]];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         out_ready_r <= 1'b0;
      end else if (replay) begin
         out_ready_r <= 1'b1;
      end else if (READ_PORT_TICK_I && (!out_ready_r || rd_req)) begin
         out_ready_r <= have_word;
      end
   end

   // two stages: first sync stage plus this register
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         almost_empty_n_r <= 1'b0;
      end else if (READ_PORT_TICK_I) begin
         almost_empty_n_r <= (fill(wr_seen1_r, rd_cur_nxt)
                              > PW'(EMPTY_OFFSET_I));
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         mode_r <= dcf_pkg::DCF_NORMAL;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // frozen at entry to the slot after the marked word
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         rd_shadow_r <= dcf_pkg::PTR_RESET;
      end else if (mode_r == dcf_pkg::DCF_NORMAL && mode_nxt == dcf_pkg::DCF_RETX) begin
         rd_shadow_r <= rd_cur_r;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         reads_past_r <= dcf_pkg::READS_RESET;
      end else if (mode_nxt != dcf_pkg::DCF_RETX || replay) begin
         reads_past_r <= dcf_pkg::READS_RESET;
      end else if (mode_r == dcf_pkg::DCF_RETX && load_word &&
                   reads_past_r != dcf_pkg::REPLAY_MIN_READS) begin
         reads_past_r <= reads_past_r + dcf_pkg::READS_ONE;
      end
   end

   // pointer that frees memory for the write side; exit switches it back
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         rd_flag_ptr_r <= dcf_pkg::PTR_RESET;
      end else if (mode_nxt == dcf_pkg::DCF_RETX) begin
         rd_flag_ptr_r <= (mode_r == dcf_pkg::DCF_RETX) ? rd_shadow_r
                                                        : rd_cur_r;
      end else begin
         rd_flag_ptr_r <= rd_cur_nxt;
      end
   end

   assign READ_DATA_O         = out_word_r;
   assign OUTPUT_READY_O      = out_ready_r;
   assign ALMOST_EMPTY_N_O    = almost_empty_n_r;
   assign INPUT_READY_O       = in_ready_r && stage_in_ready;
   assign ALMOST_FULL_N_O     = almost_full_n_r;
   assign RETRANSMIT_ACTIVE_O = (mode_r == dcf_pkg::DCF_RETX);

endmodule

// [testbench/dcf_port_model.sv]
// port clock model: free-running write and read port ticks at set periods
`timescale 1ns/1ps
module dcf_port_model (
   input  wire logic       clk_i,     // system clock
   input  wire logic       rst_i,     // sync reset, high
   input  wire logic [3:0] wr_div_i,  // write port period in clocks
   input  wire logic [3:0] rd_div_i,  // read port period in clocks
   output logic            wr_tick_o, // write port edge
   output logic            rd_tick_o  // read port edge
);
   logic [3:0] wr_cnt_r;
   logic [3:0] rd_cnt_r;
   // falling edge, so a tick never races the sampling edge
   always @(negedge clk_i) begin
      wr_cnt_r  <= (rst_i || wr_cnt_r + 4'h1 >= wr_div_i) ? 4'h0 : wr_cnt_r + 4'h1;
      wr_tick_o <= !rst_i && (wr_cnt_r + 4'h1 >= wr_div_i);
   end
   // unequal periods keep the two ports drifting against each other
   always @(negedge clk_i) begin
      rd_cnt_r  <= (rst_i || rd_cnt_r + 4'h1 >= rd_div_i) ? 4'h0 : rd_cnt_r + 4'h1;
      rd_tick_o <= !rst_i && (rd_cnt_r + 4'h1 >= rd_div_i);
   end
endmodule

// [testbench/dcf_fifo_flags_asserts.sv]
// concurrent checks on the fifo flag block ports
`timescale 1ns/1ps
module dcf_fifo_flags_asserts (
   input wire logic                       CLOCK_I,                 // clock
   input wire logic                       RST_I,                   // reset
   input wire logic                       WRITE_PORT_TICK_I,       // write edge
   input wire logic                       READ_PORT_TICK_I,        // read edge
   input wire logic                       READ_PORT_SELECT_N_I,    // select
   input wire logic                       READ_PORT_MAILBOX_SEL_I, // mailbox
   input wire logic                       READ_PORT_DIRECTION_I,   // direction
   input wire logic                       READ_PORT_STROBE_I,      // strobe
   input wire logic                       RETRANSMIT_HOLD_I,       // mode request
   input wire logic                       REPLAY_FROM_MARK_I,      // replay
   input wire logic [dcf_pkg::DATA_W-1:0] READ_DATA_O,             // word
   input wire logic                       OUTPUT_READY_O,          // ready
   input wire logic                       ALMOST_EMPTY_N_O,        // near empty
   input wire logic                       ALMOST_FULL_N_O,         // near full
   input wire logic                       RETRANSMIT_ACTIVE_O      // mode
);
   logic                       rd_sel;
   logic                       replay_go;
   logic [1:0]                 reads_r;
   logic [dcf_pkg::DATA_W-1:0] mark_r;
   assign rd_sel = !READ_PORT_SELECT_N_I && !READ_PORT_MAILBOX_SEL_I
                   && READ_PORT_DIRECTION_I && READ_PORT_STROBE_I;
   assign replay_go = RETRANSMIT_ACTIVE_O && RETRANSMIT_HOLD_I && REPLAY_FROM_MARK_I
                      && reads_r >= dcf_pkg::REPLAY_MIN_READS;
   // saturates: only the replay threshold matters
   always_ff @(posedge CLOCK_I) begin
      if (RST_I || (READ_PORT_TICK_I && (!RETRANSMIT_ACTIVE_O || replay_go)))
         reads_r <= 2'h0;
      else if (READ_PORT_TICK_I && OUTPUT_READY_O && rd_sel && reads_r != 2'h3)
         reads_r <= reads_r + 2'h1;
   end
   always_ff @(posedge CLOCK_I) begin
      if (READ_PORT_TICK_I && !RETRANSMIT_ACTIVE_O && RETRANSMIT_HOLD_I && OUTPUT_READY_O)
         mark_r <= READ_DATA_O;
   end
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);
   sequence s_starved_read;
      READ_PORT_TICK_I && !OUTPUT_READY_O ##1 !OUTPUT_READY_O;
   endsequence
   sequence s_enter;
      READ_PORT_TICK_I && RETRANSMIT_HOLD_I && OUTPUT_READY_O;
   endsequence
   sequence s_replay;
      READ_PORT_TICK_I && replay_go;
   endsequence
   AST_OR_ON_READ_TICK: assert property (
      !$past(RST_I) && !$past(READ_PORT_TICK_I) |-> $stable(OUTPUT_READY_O))
      else $error("output ready moved without a read tick");
   AST_AE_ON_READ_TICK: assert property (
      !READ_PORT_TICK_I |=> $stable(ALMOST_EMPTY_N_O))
      else $error("almost empty moved without a read tick");
   AST_AF_ON_WRITE_TICK: assert property (
      !WRITE_PORT_TICK_I |=> $stable(ALMOST_FULL_N_O))
      else $error("almost full moved without a write tick");
   AST_STALE_WORD_KEPT: assert property (
      s_starved_read |-> $stable(READ_DATA_O))
      else $error("output word changed while not ready");
   AST_NO_READ_KEEPS_WORD: assert property (
      READ_PORT_TICK_I && OUTPUT_READY_O && !rd_sel && !REPLAY_FROM_MARK_I
      |=> OUTPUT_READY_O && $stable(READ_DATA_O))
      else $error("word lost without a decoded read");
   AST_ENTER_RETX: assert property (
      s_enter |=> RETRANSMIT_ACTIVE_O)
      else $error("retransmit mode not entered");
   AST_LEAVE_RETX: assert property (
      READ_PORT_TICK_I && !RETRANSMIT_HOLD_I |=> !RETRANSMIT_ACTIVE_O)
      else $error("retransmit mode not left");
   AST_MODE_ON_TICK: assert property (
      !READ_PORT_TICK_I |=> $stable(RETRANSMIT_ACTIVE_O))
      else $error("mode moved without a read tick");
   AST_REPLAY_LOADS_MARK: assert property (
      s_replay |=> OUTPUT_READY_O && READ_DATA_O == mark_r)
      else $error("replay did not reload the marked word");
   // almost empty looks one sync stage earlier than output ready, so allow two read ticks
   AST_AE_NEEDS_WORDS: assert property (
      ALMOST_EMPTY_N_O |-> ##[0:10] OUTPUT_READY_O)
      else $error("almost empty high with nothing to read");
endmodule
bind dcf_fifo_flags dcf_fifo_flags_asserts dcf_fifo_flags_asserts_i (
   .CLOCK_I, .RST_I, .WRITE_PORT_TICK_I, .READ_PORT_TICK_I, .READ_PORT_SELECT_N_I,
   .READ_PORT_MAILBOX_SEL_I, .READ_PORT_DIRECTION_I, .READ_PORT_STROBE_I,
   .RETRANSMIT_HOLD_I, .REPLAY_FROM_MARK_I, .READ_DATA_O, .OUTPUT_READY_O,
   .ALMOST_EMPTY_N_O, .ALMOST_FULL_N_O, .RETRANSMIT_ACTIVE_O);

// [testbench/testbench.sv]
// self-checking bench for the fifo flag and retransmit block
`timescale 1ns/1ps
module testbench;
   localparam int         X    = 4;
   localparam int         Y    = 5;
   localparam logic [3:0] GOOD = 4'h3; // {select_n, mailbox, direction, strobe}
   localparam logic [3:0] IDLE = 4'h8;
   logic                       clk;
   logic                       rst;
   logic                       wr_tick;
   logic                       rd_tick;
   logic [3:0]                 wr_ctl;
   logic [3:0]                 rd_ctl;
   logic [3:0]                 wr_div;
   logic [3:0]                 rd_div;
   logic                       hold;
   logic                       replay;
   logic [31:0]                r;
   logic [dcf_pkg::DATA_W-1:0] wr_data;
   logic [dcf_pkg::DATA_W-1:0] rd_data;
   logic                       out_rdy;
   logic                       ae_n;
   logic                       in_rdy;
   logic                       af_n;
   logic                       retx;
   logic [dcf_pkg::DATA_W-1:0] q[$];
   int                         err_count = 0;
   int                         n_checks = 0;
   int                         seed = 67;
   int                         ri = 0;
   int                         mark = 0;
   int                         past = 0;
   dcf_fifo_flags dcf_fifo_flags_i (
      .CLOCK_I(clk), .RST_I(rst), .WRITE_PORT_TICK_I(wr_tick),
      .WRITE_PORT_SELECT_N_I(wr_ctl[3]), .WRITE_PORT_MAILBOX_SEL_I(wr_ctl[2]),
      .WRITE_PORT_DIRECTION_I(wr_ctl[1]), .WRITE_PORT_STROBE_I(wr_ctl[0]),
      .WRITE_DATA_I(wr_data), .READ_PORT_TICK_I(rd_tick),
      .READ_PORT_SELECT_N_I(rd_ctl[3]), .READ_PORT_MAILBOX_SEL_I(rd_ctl[2]),
      .READ_PORT_DIRECTION_I(rd_ctl[1]), .READ_PORT_STROBE_I(rd_ctl[0]),
      .RETRANSMIT_HOLD_I(hold), .REPLAY_FROM_MARK_I(replay),
      .EMPTY_OFFSET_I(11'h004), .FULL_OFFSET_I(11'h005), .READ_DATA_O(rd_data),
      .OUTPUT_READY_O(out_rdy), .ALMOST_EMPTY_N_O(ae_n), .INPUT_READY_O(in_rdy),
      .ALMOST_FULL_N_O(af_n), .RETRANSMIT_ACTIVE_O(retx));
   dcf_port_model dcf_port_model_i (.clk_i(clk), .rst_i(rst), .wr_div_i(wr_div),
      .rd_div_i(rd_div), .wr_tick_o(wr_tick), .rd_tick_o(rd_tick));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [dcf_pkg::DATA_W-1:0] seen,
                        input logic [dcf_pkg::DATA_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // the word in the output register does not count as stored
   function automatic int mem_words();
      return (q.size() > ri) ? q.size() - ri - 1 : 0;
   endfunction
   // reads pre-edge values, so it sees what the design sampled
   always @(posedge clk) begin
      if (!rst) begin
         if (out_rdy)
            check(rd_data, q[ri]);
         if (wr_tick && in_rdy && wr_ctl == GOOD)
            q.push_back(wr_data);
         if (rd_tick && retx && hold && replay && past >= 2) begin
            ri = mark;
            past = 0;
         end else if (rd_tick && out_rdy && rd_ctl == GOOD) begin
            ri++;
            past++;
         end
         if (rd_tick && !retx && hold && out_rdy) begin
            mark = ri;
            past = 0;
         end
      end
   end
   // one transfer per port tick, controls held until the tick edge
   task automatic op(input logic is_rd, input logic [3:0] ctl, input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (is_rd)
            rd_ctl = ctl;
         else begin
            wr_ctl = ctl;
            wr_data = dcf_pkg::DATA_W'({$random(seed), $random(seed)});
         end
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (!(is_rd ? rd_tick : wr_tick) && k < 64);
      end
      @(negedge clk);
      wr_ctl = IDLE;
      rd_ctl = IDLE;
   endtask
   task automatic settle();
      repeat (32) @(negedge clk);
      check(out_rdy, q.size() > ri);
      check(ae_n, mem_words() > X);
      check(af_n, mem_words() < dcf_pkg::MEM_DEPTH - Y);
      check(in_rdy, mem_words() < dcf_pkg::MEM_DEPTH);
   endtask
   initial begin
      #800000;
      err_count++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      wr_ctl = IDLE;
      rd_ctl = IDLE;
      wr_data = '0;
      hold = 1'b0;
      replay = 1'b0;
      wr_div = 4'h1;
      rd_div = 4'h2;
      repeat (3) @(negedge clk);
      check({out_rdy, ae_n, af_n, in_rdy, retx}, 5'h04);
      check(rd_data, dcf_pkg::DATA_RESET);
      rst = 1'b0;
      for (int c = 0; c < 16; c++)
         if (c != GOOD) op(1'b0, 4'(c), 1);
      settle();
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         wr_div <= 4'h1 + 4'(r[3:2]);
         rd_div <= 4'h1 + 4'(r[5:4]);
         op(r[0], (r[8:6] == 3'h0) ? r[12:9] : GOOD, 1 + int'(r[14:13]));
      end
      while (q.size() > ri)
         op(1'b1, GOOD, 1);
      settle();
      op(1'b0, GOOD, X + 1);
      settle();
      op(1'b0, GOOD, 1);
      for (int c = 0; c < 16; c++)
         if (c != GOOD) op(1'b1, 4'(c), 1);
      settle();
      op(1'b0, GOOD, dcf_pkg::MEM_DEPTH - Y - (q.size() - ri));
      settle();
      op(1'b0, GOOD, 1);
      settle();
      op(1'b0, GOOD, Y + 1);
      settle();
      op(1'b1, GOOD, 1);
      settle();
      while (q.size() > ri)
         op(1'b1, GOOD, 1);
      op(1'b0, GOOD, 8);
      settle();
      hold = 1'b1;
      op(1'b1, IDLE, 1);
      check(retx, 1'b1);
      for (int loop = 0; loop < 3; loop++) begin
         op(1'b1, GOOD, 2 + loop);
         replay = 1'b1;
         op(1'b1, IDLE, 1);
         replay = 1'b0;
      end
      op(1'b0, GOOD, 3);
      hold = 1'b0;
      op(1'b1, IDLE, 1);
      check(retx, 1'b0);
      settle();
      while (q.size() > ri)
         op(1'b1, GOOD, 1);
      settle();
      summarize();
   end
endmodule
